// ==== logic/ipi_cfg.svh ====
// Constants for the interrupt pin interface
`ifndef IPI_CFG_SVH
`define IPI_CFG_SVH
`define IPI_NUM_W 4
`define IPI_EXT_LINES 4
`define IPI_NMI_NUM 4'h1
`define IPI_EXT4_NUM 4'h4
`define IPI_ACK_CYCLES 1
`endif

// ==== logic/ipi_pkg.sv ====
// Types for the interrupt pin interface
package ipi_pkg;
    typedef logic [3:0] ipi_num_t;
    typedef enum logic [1:0] {
        IPI_IDLE = 2'b01,
        IPI_ACK = 2'b10
    } ipi_state_t;
endpackage

// ==== logic/ipi_core.sv ====
// Interrupt pin edge detection, pending latch and acknowledge with number
`timescale 1ns/10ps
`include "ipi_cfg.svh"

module ipi_core (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_nmi,
    input wire logic i_external_irq_line_4,
    input wire logic i_external_irq_line_5,
    input wire logic i_external_irq_line_6,
    input wire logic i_external_irq_line_7,
    input wire logic i_service_start,
    input wire ipi_pkg::ipi_num_t i_service_num,
    output logic [4:0] o_pending,
    output logic o_irq_acknowledge_out,
    output ipi_pkg::ipi_num_t o_serviced_irq_number
);
    import ipi_pkg::*;

    logic rst_s1_reg;
    logic rst_n_reg;
    logic [4:0] pins;
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] prev_reg;
    logic [4:0] rise;
    logic [4:0] clr;
    ipi_state_t state_reg;

    // Pending bit cleared by a service at a given table position
    function automatic logic [4:0] ipi_line_of(input ipi_num_t num);
        logic [4:0] m;
        m = 5'h00;
        if (num == `IPI_NMI_NUM) begin
            m[0] = 1'b1;
        end
        for (int k = 0; k < `IPI_EXT_LINES; k++) begin
            if (num == `IPI_EXT4_NUM + 4'(k)) begin
                m[k + 1] = 1'b1;
            end
        end
        return m;
    endfunction

    // Reset takes effect at once and is released two edges later
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // Two flops per pin, then a third holding the last level for edges
    assign pins = {i_external_irq_line_7, i_external_irq_line_6,
                   i_external_irq_line_5, i_external_irq_line_4, i_nmi};

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg <= 5'h00;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;
    assign clr = i_service_start ? ipi_line_of(i_service_num) : 5'h00;

    // Set wins over clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_pending <= 5'h00;
        end else begin
            o_pending <= (o_pending & ~clr) | rise;
        end
    end

    // Acknowledge follows each service pulse by one cycle and stays
    // high while pulses come back to back
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= IPI_IDLE;
            o_irq_acknowledge_out <= 1'b0;
            o_serviced_irq_number <= 4'h0;
        end else begin
            unique case (state_reg)
                IPI_IDLE: begin
                    if (i_service_start) begin
                        state_reg <= IPI_ACK;
                        o_irq_acknowledge_out <= 1'b1;
                        o_serviced_irq_number <= i_service_num;
                    end
                end
                IPI_ACK: begin
                    if (i_service_start) begin
                        o_serviced_irq_number <= i_service_num;
                    end else begin
                        state_reg <= IPI_IDLE;
                        o_irq_acknowledge_out <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= IPI_IDLE;
                    o_irq_acknowledge_out <= 1'b0;
                end
            endcase
        end
    end

    chk_rise_sets_pending: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        (sync2_reg[0] && !prev_reg[0]) |=> o_pending[0])
        else $error("rising edge did not set pending");
    chk_no_level_retrig: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        (!o_pending[1] && $past(sync2_reg[1]) && sync2_reg[1] && !clr[1])
        |=> !o_pending[1] || $past(rise[1]))
        else $error("pending set without edge");
    chk_ack_follows_service: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        i_service_start |=> o_irq_acknowledge_out)
        else $error("acknowledge missing after service");
    chk_ack_number_valid: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        i_service_start |=> o_serviced_irq_number == $past(i_service_num))
        else $error("wrong number during acknowledge");
    chk_ack_drops: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        !i_service_start |=> !o_irq_acknowledge_out)
        else $error("acknowledge held without service");
    chk_ext_position: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        (i_service_start && i_service_num == 4'h6 && !rise[3])
        |=> !o_pending[3])
        else $error("line 6 not cleared at position 6");
    chk_pending_cleared: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        (clr[0] && !rise[0]) |=> !o_pending[0])
        else $error("pending not cleared on service");
    chk_set_beats_clear: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        (clr[2] && rise[2]) |=> o_pending[2])
        else $error("edge lost during clear");

    chk_number_holds: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        !i_service_start |=> $stable(o_serviced_irq_number))
        else $error("number changed without service");

    chk_ack_only_after: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        o_irq_acknowledge_out |-> $past(i_service_start))
        else $error("acknowledge without service");

    // Positions outside the table acknowledge but clear nothing
    chk_unmapped_no_clear: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        (i_service_start && i_service_num != `IPI_NMI_NUM
            && (i_service_num < `IPI_EXT4_NUM
            || i_service_num > `IPI_EXT4_NUM + 4'h3))
        |=> o_pending == ($past(o_pending) | $past(rise)))
        else $error("unmapped number cleared a line");

    // Per-line checks; each line has its own fixed table position
    for (genvar g = 0; g <= `IPI_EXT_LINES; g++) begin : g_line
        localparam ipi_num_t LINE_POS = (g == 0) ? `IPI_NMI_NUM
            : `IPI_EXT4_NUM + 4'(g - 1);
        chk_line_quiet: assert property (
            @(posedge i_sys_clk) disable iff (!rst_n_reg)
            (!o_pending[g] && !rise[g]) |=> !o_pending[g])
            else $error("pending set without rising edge");

        chk_line_set: assert property (
            @(posedge i_sys_clk) disable iff (!rst_n_reg)
            rise[g] |=> o_pending[g])
            else $error("rising edge not latched");

        chk_pin_to_pending: assert property (
            @(posedge i_sys_clk) disable iff (!rst_n_reg)
            $rose(pins[g]) |-> ##3 o_pending[g])
            else $error("pin edge not pending in time");

        chk_line_keep: assert property (
            @(posedge i_sys_clk) disable iff (!rst_n_reg)
            (o_pending[g] && !(i_service_start
            && i_service_num == LINE_POS)) |=> o_pending[g])
            else $error("pending lost without its service");

        chk_line_clear: assert property (
            @(posedge i_sys_clk) disable iff (!rst_n_reg)
            (i_service_start && i_service_num == LINE_POS && !rise[g])
            |=> !o_pending[g])
            else $error("service at its position did not clear");
    end

    cov_nmi_edge: cover property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg) rise[0]);
    cov_ext_serviced: cover property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        o_pending[4] ##[1:20] (i_service_start && i_service_num == 4'h7));
    cov_back_to_back: cover property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        i_service_start [*2]);

    // Set and clear together, and a service outside the table
    cov_set_and_clear: cover property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg) clr[2] && rise[2]);

    cov_unmapped_service: cover property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        i_service_start && i_service_num == 4'h2);
endmodule

// ==== sim/ipi_src.sv ====
// Interrupt source model driving the five pins
`timescale 1ns/10ps
module ipi_src (
    input wire logic i_sys_clk,
    input wire logic [4:0] i_fire,
    output logic [4:0] o_pins
);
    // Pins change just after the edge, as a clocked source would
    always @(posedge i_sys_clk) begin
        o_pins <= i_fire;
    end
endmodule

// ==== sim/tb.sv ====
// Testbench for the interrupt pin interface
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] fire = 5'h00;
    logic [4:0] pins;
    logic svc = 1'b0;
    logic [3:0] num = 4'h0;
    logic [4:0] pend;
    logic ack;
    logic [3:0] nr;
    int n_mismatch = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    ipi_src i_ipi_src (.i_sys_clk(clk), .i_fire(fire), .o_pins(pins));
    ipi_core i_ipi_core (
        .i_sys_clk(clk),
        .i_arst_n(arst_n),
        .i_nmi(pins[0]),
        .i_external_irq_line_4(pins[1]),
        .i_external_irq_line_5(pins[2]),
        .i_external_irq_line_6(pins[3]),
        .i_external_irq_line_7(pins[4]),
        .i_service_start(svc),
        .i_service_num(num),
        .o_pending(pend),
        .o_irq_acknowledge_out(ack),
        .o_serviced_irq_number(nr)
    );
    task close_out;
        $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    // All five pins rise together; each must latch as pending
    task t_edge;
        int i;
        @(posedge clk) fire <= 5'h1F;
        for (i = 0; i < 9 && pend !== 5'h1F; i++) @(posedge clk);
        #1;
        chk(pend === 5'h1F, "pending flags not set");
        if (i == 9) close_out;
    endtask
    // Back-to-back services, one unmapped number, then level and falls
    task t_svc;
        logic [3:0] n [6];
        int i;
        n = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h2};
        for (i = 0; i < 7; i++) begin
            @(posedge clk);
            svc <= (i < 6);
            num <= (i < 6) ? n[i] : 4'h0;
            #1;
            if (i > 0) chk(ack === 1'b1, "no acknowledge");
            if (i > 0) chk(nr === n[i-1], "wrong number");
        end
        @(posedge clk) #1;
        chk(ack === 1'b0, "acknowledge stuck");
        chk(nr === 4'h2, "number not held");
        chk(pend === 5'h00, "pending not cleared");
        @(posedge clk) fire <= 5'h04;
        repeat (8) @(posedge clk);
        #1;
        chk(pend === 5'h00, "level or fall retriggered");
    endtask
    // A fresh edge on line 5 meets its own service: the set wins
    task t_set_wins;
        @(posedge clk) fire <= 5'h00;
        repeat (4) @(posedge clk);
        fire <= 5'h04;
        repeat (3) @(posedge clk);
        svc <= 1'b1;
        num <= 4'h5;
        #1;
        chk(pend === 5'h00, "pending set too early");
        @(posedge clk) svc <= 1'b0;
        #1;
        chk(pend === 5'h04, "edge lost to same-cycle clear");
        chk(ack === 1'b1 && nr === 4'h5, "no acknowledge for 5");
        @(posedge clk) svc <= 1'b1;
        @(posedge clk) svc <= 1'b0;
        #1;
        chk(pend === 5'h00, "second service did not clear");
    endtask
    // NMI edge, then a mid-run reset clears every output
    task t_reset;
        @(posedge clk) fire <= 5'h01;
        repeat (5) @(posedge clk);
        #1;
        chk(pend === 5'h01, "NMI edge not pending");
        @(posedge clk) arst_n <= 1'b0;
        fire <= 5'h00;
        #1;
        chk(pend === 5'h00 && ack === 1'b0, "reset did not clear");
        chk(nr === 4'h0, "number not reset");
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(pend === 5'h00, "pending after reset release");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_edge();
        t_svc();
        t_set_wins();
        t_reset();
        close_out();
    end
endmodule
